// ==== logic/segmr_pkg.sv ====
package segmr_pkg;
  // Register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] ADDR_MODE0 = 8'h00;
  localparam logic [7:0] ADDR_MODE1 = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_GUARDED = 8'h0C;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;

  // Reset values
  localparam logic [15:0] MODE0_RESET = 16'h0000;
  localparam logic [15:0] MODE1_RESET = 16'h0000;
  localparam logic [15:0] GUARDED_RESET = 16'h0000;

  // Mode register 0 fields
  localparam int M0_PKT_ASYNC = 15;
  localparam int M0_PKT_HALF = 14;
  localparam int M0_PKT_PAR = 13;
  localparam int M0_PKT_ILV = 12;
  localparam int M0_PKT_REQADR = 11;
  localparam int M0_CELL_WIDE = 8;
  localparam int M0_CTL_ASYNC = 7;
  localparam int M0_CTL_READY = 6;
  localparam int M0_CTL_PAR = 5;
  localparam int M0_CTL_CONT = 4;
  localparam int M0_PAR_EVEN = 2;
  localparam int M0_ON_LINE = 1;
  localparam int M0_WR_LOCK = 0;

  // Mode register 1 fields
  localparam int M1_CBR_TRIG = 15;
  localparam int M1_CBR_GATE = 13;
  localparam int M1_EARLY_WR = 12;
  localparam int M1_COSET = 10;
  localparam int M1_DQDB_CRC = 9;
  localparam int M1_HEC_SKIP = 8;

  // Reserved bits read back as zero
  localparam logic [15:0] MODE0_WMASK = 16'hF9F7;
  localparam logic [15:0] MODE1_WMASK = 16'hB700;

  // State register fields
  localparam int ST_OFF_LINE = 15;
  localparam int ST_CTL_ERROR = 11;
  localparam int ST_CBR_PEND = 0;

  // Header checksum coset pattern and CRC-8 polynomial
  localparam logic [7:0] HEC_COSET = 8'h55;
  localparam logic [7:0] HEC_POLY = 8'h07;

  // Control register command bits (write one to act)
  localparam int CTL_SM_RESET = 0;

  // Segmentation sequencer states
  typedef enum logic [1:0] {
    SEGMR_OFFLINE = 2'b00,
    SEGMR_ACTIVE = 2'b01,
    SEGMR_DRAIN = 2'b10,
    SEGMR_HALTED = 2'b11
  } segmr_seq_type;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== logic/segmr_hec_gen.sv ====
`timescale 1ns/100ps
// Header checksum over four header bytes, optional first-byte skip and coset
module segmr_hec_gen (
  // Header
  input wire logic [31:0] header,
  // Options
  input wire logic skipFirst,
  input wire logic cosetOn,
  // Result
  output logic [7:0] hec
);
  // Bitwise CRC-8 over the covered bytes, MSB first
  always_comb begin
    logic [7:0] crc;
    logic fb;
    crc = 8'h00;
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!(skipFirst && i > 23)) begin
        fb = crc[7] ^ header[i];
        crc = {crc[6:0], 1'b0} ^ (fb ? segmr_pkg::HEC_POLY : 8'h00);
      end
    end
    hec = cosetOn ? (crc ^ segmr_pkg::HEC_COSET) : crc;
  end
endmodule // segmr_hec_gen

// ==== logic/segmr_pin_mux.sv ====
`timescale 1ns/100ps
// Packet memory address pin selection and data bus drive decision
module segmr_pin_mux (
  // Address source
  input wire logic [31:0] pktAddr,
  input wire logic [31:0] pktWrData,
  // Pin controls
  input wire logic pktBusRequest,
  input wire logic pktBusGrant,
  input wire logic pktLowHalfSelect,
  input wire logic dataWrite,
  // Mode
  input wire logic halfWidth,
  input wire logic interleave,
  input wire logic addrOnDataReq,
  // Result
  output logic [15:0] addrPins,
  output logic [31:0] dataOut,
  output logic dataOe
);
  // Address presented on the 16 address pins
  always_comb begin
    if (pktLowHalfSelect) begin
      addrPins = pktAddr[15:0];
    end else if (!interleave) begin
      addrPins = pktAddr[23:8];
    end else if (halfWidth) begin
      addrPins = {pktAddr[23:9], pktAddr[1]};
    end else begin
      addrPins = {pktAddr[23:9], pktAddr[2]};
    end
  end

  // Before grant the bus floats or carries the address; after grant it carries data
  always_comb begin
    dataOut = pktWrData;
    dataOe = 1'b0;
    if (pktBusRequest && !pktBusGrant) begin
      dataOut = pktAddr;
      dataOe = pktLowHalfSelect && addrOnDataReq;
    end else if (pktBusGrant) begin
      dataOe = dataWrite;
    end
  end
endmodule // segmr_pin_mux

// ==== logic/segmr_mode_regs.sv ====
`timescale 1ns/100ps
// Behaviour
// - Mode0 bit15: packet bus sync/async
// - Async packet bus: re-request every word
// - Mode0 bit14: packet bus 32/16 bits
// - Bits 13/5 enable packet/control parity check
// - Address pins select low, high, interleaved bits
// - Bit 11 puts address on data lines while low half select is high
// - Before grant: float or address; then data
// - Mode0 bit8: cell interface 8/16 bits
// - Mode0 bit7: control bus sync/async
// - Bit6 senses control ready; ignored async
// - Bit4 zero halts on control parity error
// - Bit2 parity polarity, generate and check
// - Reset leaves device off-line
// - Clearing on-line drains, then off-line flag
// - Bit0 write-protects controlled registers
// - Rising trigger sends CBR cell, self-clears
// - Flow gate suspends CBR without transmit-on
// - Early write strobe raised with the request, not at grant
// - Header checksum with optional coset XOR
// - CRC32 appended on request, 802.6 option
// - Bit8 skips header byte zero
// - Registers are 16-bit words
// - Controlled writes only while unlocked
module segmr_mode_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Packet memory bus
  input wire logic pkt_ready_n,
  input wire logic pkt_bus_grant,
  input wire logic pkt_low_half_select,
  input wire logic [31:0] pkt_data_in,
  output logic pkt_bus_request,
  output logic pkt_cycle_start_n,
  output logic [15:0] pkt_address_pins,
  output logic [31:0] pkt_data_out,
  output logic pkt_data_oe,
  input wire logic pkt_data_parity,
  output logic pkt_parity_error,
  // Control memory bus
  input wire logic ctl_ready_n,
  input wire logic ctl_bus_grant,
  input wire logic [15:0] ctl_data_in,
  input wire logic ctl_data_parity,
  output logic ctl_bus_request,
  output logic ctl_cycle_start_n,
  output logic ctl_write_strobe,
  output logic ctl_parity_out,
  // Segmentation engine side
  input wire logic segWordReq,
  input wire logic segWordWrite,
  input wire logic [31:0] segPktAddr,
  input wire logic [31:0] segPktWrData,
  input wire logic segCtlReq,
  input wire logic segCtlWrite,
  input wire logic [15:0] segCtlWrData,
  input wire logic segCycleDone,
  input wire logic [31:0] segHeader,
  input wire logic constRateCellSent,
  input wire logic transmit_on_input,
  input wire logic append_frame_crc,
  output logic segEnable,
  output logic constRateSendReq,
  output logic frameCrcAppend,
  output logic crc32DqdbStyle,
  output logic cellIfWide,
  output logic [7:0] cellHec,
  output logic [15:0] guardedValue
);
  // Register state
  logic [15:0] mode0, next_mode0, mode1, next_mode1, guarded, next_guarded;
  logic ctlError, next_ctlError;
  logic cbrPending, next_cbrPending;
  segmr_pkg::segmr_seq_type seq, next_seq;
  // Bus state
  logic awDone, next_awDone, wDone, next_wDone;
  logic [7:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic bValid, next_bValid, rValid, next_rValid;
  logic [1:0] bResp, next_bResp, rResp, next_rResp;
  logic [31:0] rData, next_rData;
  // Pin state
  logic pktReq, next_pktReq, pktCyc, next_pktCyc;
  logic ctlReq, next_ctlReq, ctlCyc, next_ctlCyc, ctlWr, next_ctlWr;
  logic ctlParOut, next_ctlParOut, pktParErr, next_pktParErr;
  logic [15:0] addrReg, next_addrReg;
  logic [31:0] dataReg, next_dataReg;
  logic dataOeReg, next_dataOeReg;
  logic [7:0] hecReg, next_hecReg;
  // Combinational helpers
  logic [15:0] addrMux;
  logic [31:0] dataMux;
  logic dataOeMux;
  logic [7:0] hecComb;
  logic ctlParErr, ctlReadyOk, pktReadyOk, wrFire, rdFire;
  logic [15:0] wr16;

  // Parity check: odd parity means data plus parity bit has an odd count
  function automatic logic parity_bad(input logic [31:0] d, input logic p, input logic even);
    parity_bad = ((^d) ^ p) != !even;
  endfunction

  // Merge byte lanes into a 16-bit register; upper lanes are ignored
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  segmr_hec_gen u_hec (
    .header(segHeader),
    .skipFirst(mode1[segmr_pkg::M1_HEC_SKIP]),
    .cosetOn(mode1[segmr_pkg::M1_COSET]),
    .hec(hecComb)
  );

  segmr_pin_mux u_pin (
    .pktAddr(segPktAddr),
    .pktWrData(segPktWrData),
    .pktBusRequest(pktReq),
    .pktBusGrant(pkt_bus_grant),
    .pktLowHalfSelect(pkt_low_half_select),
    .dataWrite(segWordWrite),
    .halfWidth(mode0[segmr_pkg::M0_PKT_HALF]),
    .interleave(mode0[segmr_pkg::M0_PKT_ILV]),
    .addrOnDataReq(mode0[segmr_pkg::M0_PKT_REQADR]),
    .addrPins(addrMux),
    .dataOut(dataMux),
    .dataOe(dataOeMux)
  );

  // AXI4-Lite slave: address and data taken in either order, one answer each
  always_comb begin
    next_awDone = awDone;
    next_awAddr = awAddr;
    next_wDone = wDone;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = bValid;
    next_bResp = bResp;
    next_rValid = rValid;
    next_rResp = rResp;
    next_rData = rData;
    wrFire = awDone && wDone && !bValid;
    rdFire = s_axi_arvalid && !rValid;
    if (s_axi_awvalid && !awDone) begin
      next_awDone = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wDone) begin
      next_wDone = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (wrFire) begin
      next_awDone = 1'b0;
      next_wDone = 1'b0;
      next_bValid = 1'b1;
      case (awAddr)
        segmr_pkg::ADDR_MODE0, segmr_pkg::ADDR_MODE1, segmr_pkg::ADDR_GUARDED,
        segmr_pkg::ADDR_CONTROL, segmr_pkg::ADDR_STATE: next_bResp = segmr_pkg::RESP_OKAY;
        default: next_bResp = segmr_pkg::RESP_SLVERR;
      endcase
    end
    if (bValid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    if (rdFire) begin
      next_rValid = 1'b1;
      next_rResp = segmr_pkg::RESP_OKAY;
      case (s_axi_araddr)
        segmr_pkg::ADDR_MODE0: next_rData = {16'h0000, mode0};
        segmr_pkg::ADDR_MODE1: next_rData = {16'h0000, mode1};
        segmr_pkg::ADDR_GUARDED: next_rData = {16'h0000, guarded};
        segmr_pkg::ADDR_STATE: begin
          next_rData = 32'h0000_0000;
          next_rData[segmr_pkg::ST_OFF_LINE] = (seq == segmr_pkg::SEGMR_OFFLINE);
          next_rData[segmr_pkg::ST_CTL_ERROR] = ctlError;
          next_rData[segmr_pkg::ST_CBR_PEND] = cbrPending;
        end
        segmr_pkg::ADDR_CONTROL: next_rData = 32'h0000_0000;
        default: begin
          next_rData = 32'h0000_0000;
          next_rResp = segmr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awDone <= 1'b0;
      awAddr <= 8'h00;
      wDone <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      bValid <= 1'b0;
      bResp <= 2'b00;
      rValid <= 1'b0;
      rResp <= 2'b00;
      rData <= 32'h0000_0000;
    end else begin
      awDone <= next_awDone;
      awAddr <= next_awAddr;
      wDone <= next_wDone;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bValid <= next_bValid;
      bResp <= next_bResp;
      rValid <= next_rValid;
      rResp <= next_rResp;
      rData <= next_rData;
    end
  end

  // Register file, trigger bit and sequencer
  always_comb begin
    next_mode0 = mode0;
    next_mode1 = mode1;
    next_guarded = guarded;
    next_ctlError = ctlError;
    next_cbrPending = cbrPending;
    next_seq = seq;
    wr16 = 16'h0000;
    // Parity checks only count while the respective check is enabled
    ctlParErr = ctlCyc && ctlReadyOk && !ctlWr && mode0[segmr_pkg::M0_CTL_PAR] &&
                parity_bad({16'h0000, ctl_data_in}, ctl_data_parity,
                           mode0[segmr_pkg::M0_PAR_EVEN]);
    if (wrFire) begin
      case (awAddr)
        segmr_pkg::ADDR_MODE0: begin
          wr16 = lane_merge(mode0, wData, wStrb);
          next_mode0 = wr16 & segmr_pkg::MODE0_WMASK;
        end
        segmr_pkg::ADDR_MODE1: begin
          wr16 = lane_merge(mode1, wData, wStrb);
          next_mode1 = wr16 & segmr_pkg::MODE1_WMASK;
          // Only a 0-to-1 step arms a cell; rewriting a 1 does nothing
          if (wr16[segmr_pkg::M1_CBR_TRIG] && !mode1[segmr_pkg::M1_CBR_TRIG]) begin
            next_cbrPending = 1'b1;
          end
        end
        segmr_pkg::ADDR_GUARDED: begin
          if (!mode0[segmr_pkg::M0_WR_LOCK]) begin
            next_guarded = lane_merge(guarded, wData, wStrb);
          end
        end
        segmr_pkg::ADDR_CONTROL: begin
          // State-machine reset clears the halt and the error flag
          if (wStrb[0] && wData[segmr_pkg::CTL_SM_RESET]) begin
            next_ctlError = 1'b0;
            next_seq = segmr_pkg::SEGMR_OFFLINE;
          end
        end
        default: ;
      endcase
    end
    // Completion clears the trigger; a same-cycle software rising edge still wins
    if (constRateCellSent && cbrPending && !(next_cbrPending && !cbrPending)) begin
      if (!(wrFire && awAddr == segmr_pkg::ADDR_MODE1 &&
            wr16[segmr_pkg::M1_CBR_TRIG] && !mode1[segmr_pkg::M1_CBR_TRIG])) begin
        next_cbrPending = 1'b0;
        next_mode1[segmr_pkg::M1_CBR_TRIG] = 1'b0;
      end
    end
    if (ctlParErr) begin
      next_ctlError = 1'b1;
    end
    case (seq)
      segmr_pkg::SEGMR_OFFLINE: begin
        if (mode0[segmr_pkg::M0_ON_LINE] && !ctlError) begin
          next_seq = segmr_pkg::SEGMR_ACTIVE;
        end
      end
      segmr_pkg::SEGMR_ACTIVE: begin
        if (ctlParErr && !mode0[segmr_pkg::M0_CTL_CONT]) begin
          next_seq = segmr_pkg::SEGMR_HALTED;
        end else if (!mode0[segmr_pkg::M0_ON_LINE]) begin
          next_seq = segmr_pkg::SEGMR_DRAIN;
        end
      end
      segmr_pkg::SEGMR_DRAIN: begin
        // Finish the cycle under way before reporting off-line
        if (segCycleDone) begin
          next_seq = segmr_pkg::SEGMR_OFFLINE;
        end
      end
      segmr_pkg::SEGMR_HALTED: ;
      default: next_seq = segmr_pkg::SEGMR_OFFLINE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode0 <= segmr_pkg::MODE0_RESET;
      mode1 <= segmr_pkg::MODE1_RESET;
      guarded <= segmr_pkg::GUARDED_RESET;
      ctlError <= 1'b0;
      cbrPending <= 1'b0;
      seq <= segmr_pkg::SEGMR_OFFLINE;
    end else begin
      mode0 <= next_mode0;
      mode1 <= next_mode1;
      guarded <= next_guarded;
      ctlError <= next_ctlError;
      cbrPending <= next_cbrPending;
      seq <= next_seq;
    end
  end

  // Memory bus handshakes
  always_comb begin
    next_pktReq = pktReq;
    next_pktCyc = pktCyc;
    next_ctlReq = ctlReq;
    next_ctlCyc = ctlCyc;
    next_ctlWr = ctlWr;
    next_ctlParOut = ^segCtlWrData ^ !mode0[segmr_pkg::M0_PAR_EVEN];
    next_pktParErr = 1'b0;
    pktReadyOk = !pkt_ready_n;
    // Ready sensing is forced on in async mode, where the bit is ignored
    ctlReadyOk = !ctl_ready_n || (!mode0[segmr_pkg::M0_CTL_READY] &&
                                  !mode0[segmr_pkg::M0_CTL_ASYNC]);
    next_addrReg = addrMux;
    next_dataReg = dataMux;
    next_dataOeReg = dataOeMux;
    next_hecReg = hecComb;
    // Packet bus: sync streams while ready, async ends the cycle after each word
    if (!pktReq && !pktCyc && segWordReq && segEnable) begin
      next_pktReq = 1'b1;
    end else if (pktReq && pkt_bus_grant) begin
      next_pktReq = 1'b0;
      next_pktCyc = 1'b1;
    end else if (pktCyc && pktReadyOk) begin
      if (!segWordWrite && mode0[segmr_pkg::M0_PKT_PAR]) begin
        next_pktParErr = parity_bad(pkt_data_in, pkt_data_parity,
                                    mode0[segmr_pkg::M0_PAR_EVEN]);
      end
      if (mode0[segmr_pkg::M0_PKT_ASYNC] || !segWordReq) begin
        next_pktCyc = 1'b0;
      end
    end
    // Control bus: same scheme, with optional early write strobe
    if (!ctlReq && !ctlCyc && segCtlReq && segEnable) begin
      next_ctlReq = 1'b1;
      next_ctlWr = segCtlWrite && mode1[segmr_pkg::M1_EARLY_WR];
    end else if (ctlReq && ctl_bus_grant) begin
      next_ctlReq = 1'b0;
      next_ctlCyc = 1'b1;
      next_ctlWr = segCtlWrite;
    end else if (ctlCyc && ctlReadyOk) begin
      if (mode0[segmr_pkg::M0_CTL_ASYNC] || !segCtlReq) begin
        next_ctlCyc = 1'b0;
        next_ctlWr = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pktReq <= 1'b0;
      pktCyc <= 1'b0;
      ctlReq <= 1'b0;
      ctlCyc <= 1'b0;
      ctlWr <= 1'b0;
      ctlParOut <= 1'b0;
      pktParErr <= 1'b0;
      addrReg <= 16'h0000;
      dataReg <= 32'h0000_0000;
      dataOeReg <= 1'b0;
      hecReg <= 8'h00;
    end else begin
      pktReq <= next_pktReq;
      pktCyc <= next_pktCyc;
      ctlReq <= next_ctlReq;
      ctlCyc <= next_ctlCyc;
      ctlWr <= next_ctlWr;
      ctlParOut <= next_ctlParOut;
      pktParErr <= next_pktParErr;
      addrReg <= next_addrReg;
      dataReg <= next_dataReg;
      dataOeReg <= next_dataOeReg;
      hecReg <= next_hecReg;
    end
  end

  // Flow gate holds CBR back while transmit-on is low
  assign constRateSendReq = cbrPending &&
    (!mode1[segmr_pkg::M1_CBR_GATE] || transmit_on_input);
  assign segEnable = (seq == segmr_pkg::SEGMR_ACTIVE) || (seq == segmr_pkg::SEGMR_DRAIN);
  assign frameCrcAppend = append_frame_crc;
  assign crc32DqdbStyle = mode1[segmr_pkg::M1_DQDB_CRC];
  assign cellIfWide = mode0[segmr_pkg::M0_CELL_WIDE];
  assign cellHec = hecReg;
  assign guardedValue = guarded;
  assign s_axi_awready = !awDone;
  assign s_axi_wready = !wDone;
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_arready = !rValid;
  assign s_axi_rvalid = rValid;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;
  assign pkt_bus_request = pktReq;
  assign pkt_cycle_start_n = !pktCyc;
  assign pkt_address_pins = addrReg;
  assign pkt_data_out = dataReg;
  assign pkt_data_oe = dataOeReg;
  assign pkt_parity_error = pktParErr;
  assign ctl_bus_request = ctlReq;
  assign ctl_cycle_start_n = !ctlCyc;
  assign ctl_write_strobe = ctlWr;
  assign ctl_parity_out = ctlParOut;
endmodule // segmr_mode_regs

// ==== dv/segmr_mode_regs_assertions.sv ====
`timescale 1ns/100ps
// Watches bus handshakes, address pins and on-line state of the mode block
module segmr_mode_regs_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Packet memory pins and engine
  input wire logic pkt_bus_request,
  input wire logic pkt_bus_grant,
  input wire logic pkt_low_half_select,
  input wire logic pkt_data_oe,
  input wire logic [15:0] pkt_address_pins,
  input wire logic [31:0] segPktAddr,
  input wire logic segEnable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Host gets a quiet device to configure
  property p_reset_offline;
    !$past(rst_n) |-> !segEnable;
  endproperty
  a_reset_offline: assert property (p_reset_offline)
    else $error("segEnable high right after reset");
  property p_bresp_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_bresp_time: assert property (p_bresp_time)
    else $error("write response late");
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("bvalid dropped before bready");
  property p_read_time;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_time: assert property (p_read_time)
    else $error("read data late");
  // Data must not shift under a slow master
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data not held");
  property p_refused_zero;
    s_axi_rvalid && s_axi_rresp == segmr_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_refused_zero: assert property (p_refused_zero)
    else $error("refused read carries data");
  // Pins follow the mux one cycle late
  property p_addr_low;
    $past(rst_n) && $past(pkt_low_half_select) |-> pkt_address_pins == $past(segPktAddr[15:0]);
  endproperty
  a_addr_low: assert property (p_addr_low)
    else $error("low address half wrong");
  property p_float_wait;
    pkt_bus_request && !pkt_bus_grant && !pkt_low_half_select |=> !pkt_data_oe;
  endproperty
  a_float_wait: assert property (p_float_wait)
    else $error("data bus driven before grant");
endmodule // segmr_mode_regs_checker

// ==== dv/tb.sv ====
`timescale 1ns/100ps
// Register bus stimulus with queued read expectations
module tb;
  logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, cellHec;
  logic [31:0] s_axi_wdata, s_axi_rdata, pkt_data_in, pkt_data_out, segPktAddr;
  logic [31:0] segPktWrData, segHeader, a, rnd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic pkt_ready_n, pkt_bus_grant, pkt_low_half_select, pkt_bus_request, pkt_cycle_start_n;
  logic pkt_data_oe, pkt_data_parity, pkt_parity_error, ctl_ready_n, ctl_bus_grant;
  logic [15:0] pkt_address_pins, ctl_data_in, segCtlWrData, guardedValue, e;
  logic ctl_data_parity, ctl_bus_request, ctl_cycle_start_n, ctl_write_strobe, ctl_parity_out;
  logic segWordReq, segWordWrite, segCtlReq, segCtlWrite, segCycleDone, constRateCellSent;
  logic transmit_on_input, append_frame_crc, segEnable, constRateSendReq, frameCrcAppend;
  logic crc32DqdbStyle, cellIfWide;
  logic [33:0] expQ[$];
  int seed = 92;
  int badCount = 0;
  int samplesChecked = 0;
  int cycles = 0;

  segmr_mode_regs dut (.*);

  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [33:0] x, input logic [33:0] s);
    samplesChecked++;
    if (s !== x) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic end_sim;
    if (badCount == 0 && samplesChecked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Write; bready held back a cycle so the response must wait for us
  task automatic wr(input logic [7:0] ad, input logic [15:0] d, input logic [1:0] r);
    @(posedge sys_clk);
    rnd = $random(seed);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {rnd[31:16], d};
    s_axi_wstrb <= 4'h3;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!s_axi_bvalid) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h1;
    @(posedge sys_clk);
    s_axi_bready <= 1'h0;
    chk("bresp", {32'h0, r}, {32'h0, s_axi_bresp});
  endtask

  // Read; the watcher below compares the data
  task automatic rd(input logic [7:0] ad, input logic [33:0] x);
    @(posedge sys_clk);
    expQ.push_back(x);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    while (!s_axi_rvalid) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h1;
    @(posedge sys_clk);
    s_axi_rready <= 1'h0;
  endtask

  function automatic logic [7:0] hec(input logic [31:0] h, input logic sk, input logic co);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 31; b >= 0; b--) begin
      if (!(sk && b > 23)) c = {c[6:0], 1'h0} ^ ((c[7] ^ h[b]) ? segmr_pkg::HEC_POLY : 8'h00);
    end
    return co ? c ^ segmr_pkg::HEC_COSET : c;
  endfunction

  // Read results, oldest expectation first
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) chk("rdata", expQ.pop_front(), {s_axi_rresp, s_axi_rdata});
  end

  // Memory and engine inputs wander so the pin logic sees traffic
  always @(posedge sys_clk) begin
    {pkt_ready_n, pkt_bus_grant, pkt_data_parity, ctl_ready_n, ctl_bus_grant} <= 5'($random(seed));
    {ctl_data_parity, segWordReq, segWordWrite, segCtlReq, segCtlWrite} <= 5'($random(seed));
    append_frame_crc <= 1'($random(seed));
    pkt_data_in <= $random(seed);
    segPktWrData <= $random(seed);
    {ctl_data_in, segCtlWrData} <= $random(seed);
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      badCount++;
      end_sim();
    end
  end

  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
     s_axi_araddr, s_axi_wdata, s_axi_wstrb, pkt_low_half_select, segPktAddr, segHeader,
     segCycleDone, constRateCellSent, transmit_on_input} <= '0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'h1;
    rd(segmr_pkg::ADDR_MODE0, 34'h0);
    rd(segmr_pkg::ADDR_STATE, 34'h8000);
    rd(segmr_pkg::ADDR_GUARDED, 34'h0);
    wr(segmr_pkg::ADDR_MODE0, segmr_pkg::MODE0_WMASK, segmr_pkg::RESP_OKAY);
    rd(segmr_pkg::ADDR_MODE0, {18'h0, segmr_pkg::MODE0_WMASK});
    chk("cellIfWide", 34'h1, {33'h0, cellIfWide});
    // Locked: the write is swallowed but still answered OKAY
    wr(segmr_pkg::ADDR_GUARDED, 16'h1234, segmr_pkg::RESP_OKAY);
    rd(segmr_pkg::ADDR_GUARDED, 34'h0);
    wr(segmr_pkg::ADDR_MODE0, 16'h0040, segmr_pkg::RESP_OKAY);
    wr(segmr_pkg::ADDR_GUARDED, 16'h1234, segmr_pkg::RESP_OKAY);
    rd(segmr_pkg::ADDR_GUARDED, 34'h1234);
    chk("guardedValue", 34'h1234, {18'h0, guardedValue});
    wr(segmr_pkg::ADDR_CONTROL, 16'h0001, segmr_pkg::RESP_OKAY);
    wr(8'h14, 16'h00FF, segmr_pkg::RESP_SLVERR);
    rd(8'h14, {segmr_pkg::RESP_SLVERR, 32'h0});
    wr(segmr_pkg::ADDR_MODE1, 16'h0200, segmr_pkg::RESP_OKAY);
    chk("crc32Dqdb", 34'h1, {33'h0, crc32DqdbStyle});
    chk("crcAppend", {33'h0, append_frame_crc}, {33'h0, frameCrcAppend});
    // Address pin selection for each width and interleave setting
    for (int i = 0; i < 6; i++) begin
      wr(segmr_pkg::ADDR_MODE0, (i < 2) ? 16'h0040 : (i < 4) ? 16'h1040 : 16'h5040, 2'h0);
      a = $random(seed);
      segPktAddr <= a;
      pkt_low_half_select <= i[0];
      repeat (3) @(posedge sys_clk);
      e = i[0] ? a[15:0] : (i < 2) ? a[23:8] : {a[23:9], (i < 4) ? a[2] : a[1]};
      chk("addrPins", {18'h0, e}, {18'h0, pkt_address_pins});
    end
    for (int i = 0; i < 4; i++) begin
      wr(segmr_pkg::ADDR_MODE1, {5'h00, i[1], 1'h0, i[0], 8'h00}, 2'h0);
      a = $random(seed);
      segHeader <= a;
      repeat (3) @(posedge sys_clk);
      chk("cellHec", {26'h0, hec(a, i[0], i[1])}, {26'h0, cellHec});
    end
    // Going off-line waits for the running cycle to finish
    wr(segmr_pkg::ADDR_MODE0, 16'h0042, 2'h0);
    chk("segOn", 34'h1, {33'h0, segEnable});
    wr(segmr_pkg::ADDR_MODE0, 16'h0040, 2'h0);
    chk("segDrain", 34'h1, {33'h0, segEnable});
    segCycleDone <= 1'h1;
    @(posedge sys_clk);
    segCycleDone <= 1'h0;
    repeat (2) @(posedge sys_clk);
    chk("segOff", 34'h0, {33'h0, segEnable});
    rd(segmr_pkg::ADDR_STATE, 34'h8000);
    wr(segmr_pkg::ADDR_MODE0, 16'h0042, 2'h0);
    wr(segmr_pkg::ADDR_MODE1, 16'h8000, 2'h0);
    chk("cbrReq", 34'h1, {33'h0, constRateSendReq});
    rd(segmr_pkg::ADDR_MODE1, 34'h8000);
    constRateCellSent <= 1'h1;
    @(posedge sys_clk);
    constRateCellSent <= 1'h0;
    rd(segmr_pkg::ADDR_MODE1, 34'h0);
    wr(segmr_pkg::ADDR_MODE1, 16'hA000, 2'h0);
    chk("cbrGated", 34'h0, {33'h0, constRateSendReq});
    transmit_on_input <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk("cbrFree", 34'h1, {33'h0, constRateSendReq});
    repeat (3) @(posedge sys_clk);
    end_sim();
  end
endmodule // tb

bind segmr_mode_regs segmr_mode_regs_checker chk_i (.*);
